// *** hw/ptis_pkg.sv ***
// Package for the pin/timer interrupt and sleep control block.
// Assumes a single CPU clock domain and the plain register port.
package ptis_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] TIMER_IRQ_MASK_ADDR = 8'h39;
  localparam logic [7:0] PIN_IRQ_MASK_ADDR = 8'h3B;
  localparam logic [7:0] PIN_IRQ_FLAGS_ADDR = 8'h3A;
  localparam logic [7:0] TIMER_IRQ_FLAGS_ADDR = 8'h38;
  localparam logic [7:0] CORE_CONTROL_ADDR = 8'h35;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EXT_IRQ0_BIT = 6;
  localparam int PIN_CHANGE_BIT = 5;
  localparam int OVERFLOW_BIT = 1;
  localparam int PULLUP_DISABLE_BIT = 6;
  localparam int SLEEP_ALLOW_BIT = 5;
  localparam int SLEEP_SELECT_BIT = 4;

  // Writable bits of each register; everything else reads zero
  localparam logic [7:0] PIN_MASK_BITS = 8'h60;
  localparam logic [7:0] TIMER_MASK_BITS = 8'h02;
  localparam logic [7:0] CTRL_MASK_BITS = 8'h73;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] PINS_RESET = 6'h00;

  // ****************************************
  // Vectors and sense encodings
  // ****************************************
  localparam logic [8:0] VEC_EXT_IRQ0 = 9'h001;
  localparam logic [8:0] VEC_PIN_CHANGE = 9'h002;
  localparam logic [8:0] VEC_OVERFLOW = 9'h003;
  localparam logic [8:0] VEC_NONE = 9'h000;

  typedef enum logic [1:0] {
    PTIS_SENSE_LOW = 2'h0,
    PTIS_SENSE_ANY = 2'h1,
    PTIS_SENSE_FALL = 2'h2,
    PTIS_SENSE_RISE = 2'h3
  } ptis_sense_t;

endpackage : ptis_pkg

// *** hw/ptis_irq_ctrl.sv ***
// Interrupt enables, flags, vector selection and sleep control.
// Assumes pins and core signals are synchronous to core_clk.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - External interrupt enabled when its mask bit 6 and global enable are set.
// - Two sense bits choose rising, falling, any change or low level.
// - Pin activity requests the external interrupt even when the pin drives out.
// - External interrupt vectors to address 001.
// - Pin change enabled by mask bit 5 and global enable; vector 002.
// - Edge request sets flag bit 6; cleared on vector entry or writing one.
// - In low-level sense the external flag stays zero.
// - Pin event sets flag bit 5; cleared on vector entry or writing one.
// - Overflow interrupt at vector 003 when mask bit 1, global, flag set.
// - Overflow sets flag bit 1; cleared on vector entry or writing one.
// - Reserved bits of every register read as zero.
// - Low three pins always request; high three only when configured input.
// - Pin change request raised even when a low pin is an output; high output pins never raise it.
// - One pin event may raise pin change and external requests together.
// - Pins sampled on core clock before edge detection; one-clock pulses seen.
// - Low-level mode keeps requesting while the pin stays low.
// - Control bit 6 disables all port pull-ups.
// - Sleep instruction sleeps only while control bit 5 is set.
// - Control bit 4 selects idle (0) or power-down (1).
// - Sense codes: 00 low, 01 any change, 10 falling, 11 rising.
module ptis_irq_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pins and sources
  input wire logic ext_irq0_pin,
  input wire logic [2:0] low_port_pins,
  input wire logic [2:0] high_port_pins,
  input wire logic [2:0] high_pin_is_input,
  input wire logic timer_overflow,
  // Core side
  input wire logic status_word_ie,
  input wire logic irq_ack,
  input wire logic sleep_exec,
  output logic irq_req,
  output logic [8:0] irq_vector,
  output logic sleep_enter,
  output logic sleep_power_down,
  output logic pullup_disable
);
  import ptis_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] pin_irq_mask_r;
  logic [7:0] timer_irq_mask_r;
  logic [7:0] core_control_r;
  logic ext_irq0_flag_r;
  logic pin_change_irq_flag_r;
  logic overflow_flag_r;
  logic ext_pin_r;
  logic [5:0] port_pins_r;
  logic [7:0] reg_rdata_r;
  logic [8:0] irq_vector_r;
  logic irq_req_r;

  logic wr_pin_mask, wr_tmr_mask, wr_ctrl, wr_pin_flags, wr_tmr_flags;
  logic ext_edge, pin_event, ext_level_req;
  logic ack_ext, ack_pc, ack_ovf;
  logic en_ext, en_pc, en_ovf;
  logic [8:0] vector_nxt;
  ptis_sense_t sense;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b, input logic s);
    hit = s && (a == b);
  endfunction : hit

  assign wr_pin_mask = hit(reg_addr, PIN_IRQ_MASK_ADDR, reg_wr);
  assign wr_tmr_mask = hit(reg_addr, TIMER_IRQ_MASK_ADDR, reg_wr);
  assign wr_ctrl = hit(reg_addr, CORE_CONTROL_ADDR, reg_wr);
  assign wr_pin_flags = hit(reg_addr, PIN_IRQ_FLAGS_ADDR, reg_wr);
  assign wr_tmr_flags = hit(reg_addr, TIMER_IRQ_FLAGS_ADDR, reg_wr);

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_irq_mask_r <= REG_RESET;
    end else if (wr_pin_mask) begin
      pin_irq_mask_r <= reg_wdata & PIN_MASK_BITS;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_irq_mask_r <= REG_RESET;
    end else if (wr_tmr_mask) begin
      timer_irq_mask_r <= reg_wdata & TIMER_MASK_BITS;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_control_r <= REG_RESET;
    end else if (wr_ctrl) begin
      core_control_r <= reg_wdata & CTRL_MASK_BITS;
    end
  end

  assign sense = ptis_sense_t'(core_control_r[1:0]);
  assign pullup_disable = core_control_r[PULLUP_DISABLE_BIT];
  assign sleep_enter = sleep_exec && core_control_r[SLEEP_ALLOW_BIT];
  assign sleep_power_down = core_control_r[SLEEP_SELECT_BIT];

  // ****************************************
  // Pin sampling and event detection
  // ****************************************
  // Pins are read regardless of direction, so driven ext and low pins also trigger
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_pin_r <= 1'b1;
      port_pins_r <= PINS_RESET;
    end else begin
      ext_pin_r <= ext_irq0_pin;
      port_pins_r <= {high_port_pins, low_port_pins};
    end
  end

  always_comb begin
    unique case (sense)
      PTIS_SENSE_ANY: ext_edge = ext_pin_r != ext_irq0_pin;
      PTIS_SENSE_FALL: ext_edge = ext_pin_r && !ext_irq0_pin;
      PTIS_SENSE_RISE: ext_edge = !ext_pin_r && ext_irq0_pin;
      PTIS_SENSE_LOW: ext_edge = 1'b0;
    endcase
  end

  assign ext_level_req = (sense == PTIS_SENSE_LOW) && !ext_irq0_pin;
  // Independent detectors let one event raise both requests
  assign pin_event = |(low_port_pins ^ port_pins_r[2:0]) ||
                     |((high_port_pins ^ port_pins_r[5:3]) & high_pin_is_input);

  // ****************************************
  // Flags (set wins over clear)
  // ****************************************
  assign ack_ext = irq_ack && irq_vector_r == VEC_EXT_IRQ0;
  assign ack_pc = irq_ack && irq_vector_r == VEC_PIN_CHANGE;
  assign ack_ovf = irq_ack && irq_vector_r == VEC_OVERFLOW;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_irq0_flag_r <= 1'b0;
    end else if (sense == PTIS_SENSE_LOW) begin
      ext_irq0_flag_r <= 1'b0;
    end else if (ext_edge) begin
      ext_irq0_flag_r <= 1'b1;
    end else if (ack_ext || (wr_pin_flags && reg_wdata[EXT_IRQ0_BIT])) begin
      ext_irq0_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_change_irq_flag_r <= 1'b0;
    end else if (pin_event) begin
      pin_change_irq_flag_r <= 1'b1;
    end else if (ack_pc || (wr_pin_flags && reg_wdata[PIN_CHANGE_BIT])) begin
      pin_change_irq_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_flag_r <= 1'b0;
    end else if (timer_overflow) begin
      overflow_flag_r <= 1'b1;
    end else if (ack_ovf || (wr_tmr_flags && reg_wdata[OVERFLOW_BIT])) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // Request and vector
  // ****************************************
  assign en_ext = status_word_ie && pin_irq_mask_r[EXT_IRQ0_BIT] &&
                  (ext_irq0_flag_r || ext_level_req);
  assign en_pc = status_word_ie && pin_irq_mask_r[PIN_CHANGE_BIT] &&
                 pin_change_irq_flag_r;
  assign en_ovf = status_word_ie && timer_irq_mask_r[OVERFLOW_BIT] &&
                  overflow_flag_r;

  always_comb begin
    if (en_ext) begin
      vector_nxt = VEC_EXT_IRQ0;
    end else if (en_pc) begin
      vector_nxt = VEC_PIN_CHANGE;
    end else if (en_ovf) begin
      vector_nxt = VEC_OVERFLOW;
    end else begin
      vector_nxt = VEC_NONE;
    end
  end

  // One-cycle pipeline; an ack blanks the request for the following cycle
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_vector_r <= VEC_NONE;
      irq_req_r <= 1'b0;
    end else if (irq_ack) begin
      irq_vector_r <= VEC_NONE;
      irq_req_r <= 1'b0;
    end else begin
      irq_vector_r <= vector_nxt;
      irq_req_r <= vector_nxt != VEC_NONE;
    end
  end

  assign irq_req = irq_req_r;
  assign irq_vector = irq_vector_r;

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= REG_RESET;
    end else if (!reg_rd) begin
      reg_rdata_r <= REG_RESET;
    end else begin
      unique case (reg_addr)
        PIN_IRQ_MASK_ADDR: reg_rdata_r <= pin_irq_mask_r;
        TIMER_IRQ_MASK_ADDR: reg_rdata_r <= timer_irq_mask_r;
        CORE_CONTROL_ADDR: reg_rdata_r <= core_control_r;
        PIN_IRQ_FLAGS_ADDR: reg_rdata_r <= {1'b0, ext_irq0_flag_r, pin_change_irq_flag_r,
                                            5'h00};
        TIMER_IRQ_FLAGS_ADDR: reg_rdata_r <= {6'h00, overflow_flag_r, 1'b0};
        default: reg_rdata_r <= REG_RESET;
      endcase
    end
  end

  assign reg_rdata = reg_rdata_r;

  // ****************************************
  // Checks
  // ****************************************
  a_low_flag_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    sense == PTIS_SENSE_LOW |=> !ext_irq0_flag_r) else $error("ext flag set in level mode");
  a_ovf_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    timer_overflow |=> overflow_flag_r) else $error("overflow flag not set");
  a_pc_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    pin_event |=> pin_change_irq_flag_r) else $error("pin change flag not set");
  a_edge_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    ext_edge && sense != PTIS_SENSE_LOW |=> ext_irq0_flag_r) else $error("ext flag not set");
  a_ovf_vector: assert property (@(posedge core_clk) disable iff (!rst_b)
    irq_req && irq_vector == VEC_OVERFLOW |-> $past(overflow_flag_r) &&
    $past(timer_irq_mask_r[OVERFLOW_BIT]) && $past(status_word_ie)) else $error("bad ovf req");
  a_ext_priority: assert property (@(posedge core_clk) disable iff (!rst_b)
    en_ext && !irq_ack |=> irq_vector == VEC_EXT_IRQ0) else $error("ext not first");
  a_no_ie_no_req: assert property (@(posedge core_clk) disable iff (!rst_b)
    !status_word_ie |=> !irq_req) else $error("request without global enable");
  a_sleep_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
    sleep_enter |-> core_control_r[SLEEP_ALLOW_BIT]) else $error("sleep without allow");
  a_level_req: assert property (@(posedge core_clk) disable iff (!rst_b)
    ext_level_req && status_word_ie && pin_irq_mask_r[EXT_IRQ0_BIT] && !irq_ack
    |=> irq_req && irq_vector == VEC_EXT_IRQ0) else $error("level request lost");

  // ****************************************
  // Flag clear and hold checks
  // ****************************************
  // Clears only bite when no set event falls in the same cycle
  a_ovf_clr_ack: assert property (@(posedge core_clk) disable iff (!rst_b)
    ack_ovf && !timer_overflow |=> !overflow_flag_r) else $error("ovf flag kept after ack");
  a_ovf_clr_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_tmr_flags && reg_wdata[OVERFLOW_BIT] && !timer_overflow |=> !overflow_flag_r)
    else $error("ovf flag kept after write one");
  a_ovf_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    overflow_flag_r && !ack_ovf && !(wr_tmr_flags && reg_wdata[OVERFLOW_BIT])
    |=> overflow_flag_r) else $error("ovf flag lost");
  a_ovf_wr_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    overflow_flag_r && wr_tmr_flags && !reg_wdata[OVERFLOW_BIT] && !ack_ovf
    |=> overflow_flag_r) else $error("ovf flag cleared by zero");
  a_pc_clr_ack: assert property (@(posedge core_clk) disable iff (!rst_b)
    ack_pc && !pin_event |=> !pin_change_irq_flag_r) else $error("pc flag kept after ack");
  a_pc_clr_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_pin_flags && reg_wdata[PIN_CHANGE_BIT] && !pin_event |=> !pin_change_irq_flag_r)
    else $error("pc flag kept after write one");
  a_pc_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    pin_change_irq_flag_r && !ack_pc && !(wr_pin_flags && reg_wdata[PIN_CHANGE_BIT])
    |=> pin_change_irq_flag_r) else $error("pc flag lost");
  a_ext_clr_ack: assert property (@(posedge core_clk) disable iff (!rst_b)
    ack_ext && !ext_edge |=> !ext_irq0_flag_r) else $error("ext flag kept after ack");
  a_ext_clr_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_pin_flags && reg_wdata[EXT_IRQ0_BIT] && !ext_edge |=> !ext_irq0_flag_r)
    else $error("ext flag kept after write one");
  a_ext_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    ext_irq0_flag_r && sense != PTIS_SENSE_LOW && !ack_ext &&
    !(wr_pin_flags && reg_wdata[EXT_IRQ0_BIT]) |=> ext_irq0_flag_r) else $error("ext flag lost");

  // ****************************************
  // Edge and pin event checks
  // ****************************************
  a_fall_edge: assert property (@(posedge core_clk) disable iff (!rst_b)
    sense == PTIS_SENSE_FALL && ext_pin_r && !ext_irq0_pin |=> ext_irq0_flag_r)
    else $error("falling edge missed");
  a_rise_edge: assert property (@(posedge core_clk) disable iff (!rst_b)
    sense == PTIS_SENSE_RISE && !ext_pin_r && ext_irq0_pin |=> ext_irq0_flag_r)
    else $error("rising edge missed");
  a_any_edge: assert property (@(posedge core_clk) disable iff (!rst_b)
    sense == PTIS_SENSE_ANY && ext_pin_r != ext_irq0_pin |=> ext_irq0_flag_r)
    else $error("pin change on ext missed");
  a_low_pins_event: assert property (@(posedge core_clk) disable iff (!rst_b)
    low_port_pins != port_pins_r[2:0] |=> pin_change_irq_flag_r) else $error("low pin missed");
  a_pc_high_pin: assert property (@(posedge core_clk) disable iff (!rst_b)
    |((high_port_pins ^ port_pins_r[5:3]) & high_pin_is_input) |=> pin_change_irq_flag_r)
    else $error("high input pin missed");
  a_out_pin_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
    !pin_change_irq_flag_r && low_port_pins == port_pins_r[2:0] &&
    ((high_port_pins ^ port_pins_r[5:3]) & high_pin_is_input) == 3'h0
    |=> !pin_change_irq_flag_r) else $error("pc flag without event");
  a_both_requests: assert property (@(posedge core_clk) disable iff (!rst_b)
    sense == PTIS_SENSE_ANY && ext_pin_r != ext_irq0_pin && pin_event
    |=> ext_irq0_flag_r && pin_change_irq_flag_r) else $error("shared event lost");

  // ****************************************
  // Request and vector checks
  // ****************************************
  a_ext_vector: assert property (@(posedge core_clk) disable iff (!rst_b)
    irq_req && irq_vector == VEC_EXT_IRQ0 |-> $past(status_word_ie) &&
    $past(pin_irq_mask_r[EXT_IRQ0_BIT])) else $error("bad ext req");
  a_pc_vector: assert property (@(posedge core_clk) disable iff (!rst_b)
    irq_req && irq_vector == VEC_PIN_CHANGE |-> $past(pin_change_irq_flag_r) &&
    $past(pin_irq_mask_r[PIN_CHANGE_BIT]) && $past(status_word_ie)) else $error("bad pc req");
  a_pc_over_ovf: assert property (@(posedge core_clk) disable iff (!rst_b)
    en_pc && !en_ext && !irq_ack |=> irq_vector == VEC_PIN_CHANGE) else $error("pc not second");
  a_ovf_last: assert property (@(posedge core_clk) disable iff (!rst_b)
    en_ovf && !en_ext && !en_pc && !irq_ack |=> irq_vector == VEC_OVERFLOW)
    else $error("ovf request lost");
  a_no_mask_no_ovf: assert property (@(posedge core_clk) disable iff (!rst_b)
    !timer_irq_mask_r[OVERFLOW_BIT] |=> irq_vector != VEC_OVERFLOW) else $error("masked ovf");
  a_ack_blanks: assert property (@(posedge core_clk) disable iff (!rst_b)
    irq_ack |=> !irq_req) else $error("request not blanked after ack");
  a_req_vec_pair: assert property (@(posedge core_clk) disable iff (!rst_b)
    irq_req == (irq_vector != VEC_NONE)) else $error("request and vector disagree");

  // ****************************************
  // Register and control checks
  // ****************************************
  a_pin_mask_rsvd: assert property (@(posedge core_clk) disable iff (!rst_b)
    (pin_irq_mask_r & ~PIN_MASK_BITS) == 8'h00) else $error("pin mask reserved set");
  a_tmr_mask_rsvd: assert property (@(posedge core_clk) disable iff (!rst_b)
    (timer_irq_mask_r & ~TIMER_MASK_BITS) == 8'h00) else $error("timer mask reserved set");
  a_ctrl_rsvd: assert property (@(posedge core_clk) disable iff (!rst_b)
    (core_control_r & ~CTRL_MASK_BITS) == 8'h00) else $error("control reserved set");
  a_rd_flags_rsvd: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_rd && reg_addr == PIN_IRQ_FLAGS_ADDR |=> (reg_rdata & 8'h9F) == 8'h00)
    else $error("flag reserved bits read");
  a_rdata_idle: assert property (@(posedge core_clk) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data without read");
  a_sleep_allowed: assert property (@(posedge core_clk) disable iff (!rst_b)
    sleep_exec && core_control_r[SLEEP_ALLOW_BIT] |-> sleep_enter) else $error("sleep refused");
  a_pullup_follows: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_ctrl |=> pullup_disable == $past(reg_wdata[PULLUP_DISABLE_BIT]))
    else $error("pull-up disable not written");
  a_mode_follows: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_ctrl |=> sleep_power_down == $past(reg_wdata[SLEEP_SELECT_BIT]))
    else $error("sleep mode not written");

endmodule : ptis_irq_ctrl

`default_nettype wire

// *** tb/ptis_core_model.sv ***
// Core model: acknowledges pending interrupt requests.
// Assumes the bench enables it and picks the acknowledge delay.
`timescale 1ns/1ns
`default_nettype none
module ptis_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Request side
  input wire logic irq_req,
  input wire logic auto_ack,
  input wire logic [1:0] ack_delay,
  output logic irq_ack
);
  logic [1:0] wait_r;

  // One-cycle acknowledge after the request has waited ack_delay cycles
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack <= 1'b0;
      wait_r <= 2'h0;
    end else if (irq_ack || !irq_req || !auto_ack) begin
      irq_ack <= 1'b0;
      wait_r <= 2'h0;
    end else if (wait_r == ack_delay) begin
      irq_ack <= 1'b1;
    end else begin
      wait_r <= wait_r + 2'h1;
    end
  end
endmodule : ptis_core_model
`default_nettype wire

// *** tb/test_pin_timer_irq_sleep_control.sv ***
// Testbench for the pin/timer interrupt and sleep control block.
// Assumes ptis_pkg, ptis_irq_ctrl and ptis_core_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end
module test_pin_timer_irq_sleep_control;
  import ptis_pkg::*;
  logic core_clk, rst_b, reg_wr, reg_rd, ext_irq0_pin, timer_overflow, status_word_ie;
  logic irq_ack, sleep_exec, irq_req, sleep_enter, sleep_power_down, pullup_disable;
  logic auto_ack, rd_d, fire;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, exp_rd;
  logic [2:0] low_port_pins, high_port_pins, high_pin_is_input, hi_sel;
  logic [8:0] irq_vector, exp_vec;
  logic [1:0] ack_delay;
  logic [7:0] rd_q[$];
  logic [8:0] vec_q[$];
  logic [7:0] ra[5] = '{TIMER_IRQ_MASK_ADDR, PIN_IRQ_MASK_ADDR, CORE_CONTROL_ADDR,
                        PIN_IRQ_FLAGS_ADDR, TIMER_IRQ_FLAGS_ADDR};
  logic [7:0] rm[5] = '{TIMER_MASK_BITS, PIN_MASK_BITS, CTRL_MASK_BITS, 8'h00, 8'h00};
  int errors, checks, cyc_cnt, seed;

  ptis_irq_ctrl dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_irq0_pin(ext_irq0_pin), .low_port_pins(low_port_pins),
    .high_port_pins(high_port_pins), .high_pin_is_input(high_pin_is_input),
    .timer_overflow(timer_overflow), .status_word_ie(status_word_ie), .irq_ack(irq_ack),
    .sleep_exec(sleep_exec), .irq_req(irq_req), .irq_vector(irq_vector),
    .sleep_enter(sleep_enter), .sleep_power_down(sleep_power_down),
    .pullup_disable(pullup_disable));
  ptis_core_model core_u (.core_clk(core_clk), .rst_b(rst_b), .irq_req(irq_req),
    .auto_ack(auto_ack), .ack_delay(ack_delay), .irq_ack(irq_ack));

  always #10 core_clk = ~core_clk;

  task automatic final_report();
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rd_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic slp(input logic e);
    @(posedge core_clk);
    sleep_exec <= 1'b1;
    #1 `CHK(sleep_enter, e);
    @(posedge core_clk);
    sleep_exec <= 1'b0;
  endtask : slp

  // ****************************************
  // Result watcher and hang guard
  // ****************************************
  always @(posedge core_clk) begin
    if (rd_d) begin
      exp_rd = rd_q.pop_front();
      `CHK(reg_rdata, exp_rd)
    end
    if (irq_ack) begin
      exp_vec = vec_q.pop_front();
      `CHK(irq_vector, exp_vec)
    end
    rd_d <= reg_rd;
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    {core_clk, rst_b, reg_wr, reg_rd, timer_overflow, status_word_ie} = '0;
    {sleep_exec, auto_ack, rd_d, reg_addr, reg_wdata, ack_delay} = '0;
    {low_port_pins, high_port_pins, high_pin_is_input} = '0;
    ext_irq0_pin = 1'b1;
    seed = $urandom(32'h9a5d);
    cyc(4);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], REG_RESET);
      wr(ra[i], 8'hff);
      rd(ra[i], rm[i]);
      wr(ra[i], 8'h00);
    end
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    wr(CORE_CONTROL_ADDR, 8'h50);
    cyc(1);
    `CHK(pullup_disable, 1'b1);
    `CHK(sleep_power_down, 1'b1);
    slp(1'b0);
    wr(CORE_CONTROL_ADDR, 8'h20);
    slp(1'b1);
    `CHK(pullup_disable, 1'b0);
    `CHK(sleep_power_down, 1'b0);
    // Sense codes 1..3 with both pin edges; global enable stays off
    for (int m = 1; m < 4; m++) begin
      wr(CORE_CONTROL_ADDR, 8'(m));
      for (int k = 0; k < 2; k++) begin
        @(posedge core_clk);
        ext_irq0_pin <= ~ext_irq0_pin;
        fire = (m == 1) || (m == 3 && k == 1) || (m == 2 && k == 0);
        cyc(3);
        wr(PIN_IRQ_FLAGS_ADDR, 8'h00);
        rd(PIN_IRQ_FLAGS_ADDR, fire ? 8'h40 : 8'h00);
        wr(PIN_IRQ_FLAGS_ADDR, 8'hff);
      end
    end
    // Pin change: high pins gated by direction, one-cycle low pin pulse
    @(posedge core_clk);
    high_port_pins <= 3'h7;
    cyc(3);
    rd(PIN_IRQ_FLAGS_ADDR, 8'h00);
    hi_sel = 3'h1 << ($urandom % 3);
    high_pin_is_input <= hi_sel;
    high_port_pins <= 3'h7 ^ hi_sel;
    cyc(3);
    rd(PIN_IRQ_FLAGS_ADDR, 8'h20);
    wr(PIN_IRQ_FLAGS_ADDR, 8'hff);
    rd(PIN_IRQ_FLAGS_ADDR, 8'h00);
    low_port_pins <= 3'($urandom_range(1, 7));
    @(posedge core_clk);
    low_port_pins <= 3'h0;
    cyc(3);
    rd(PIN_IRQ_FLAGS_ADDR, 8'h20);
    // All three sources pending at once, then taken in vector order
    wr(CORE_CONTROL_ADDR, 8'h01);
    wr(PIN_IRQ_MASK_ADDR, 8'h60);
    wr(TIMER_IRQ_MASK_ADDR, 8'h02);
    @(posedge core_clk);
    ext_irq0_pin <= 1'b0;
    low_port_pins <= 3'h1;
    timer_overflow <= 1'b1;
    @(posedge core_clk);
    timer_overflow <= 1'b0;
    cyc(3);
    rd(PIN_IRQ_FLAGS_ADDR, 8'h60);
    rd(TIMER_IRQ_FLAGS_ADDR, 8'h02);
    vec_q = '{VEC_EXT_IRQ0, VEC_PIN_CHANGE, VEC_OVERFLOW};
    ack_delay <= 2'($urandom % 4);
    auto_ack <= 1'b1;
    status_word_ie <= 1'b1;
    cyc(30);
    rd(PIN_IRQ_FLAGS_ADDR, 8'h00);
    rd(TIMER_IRQ_FLAGS_ADDR, 8'h00);
    // Low-level sense with the pin already low
    auto_ack <= 1'b0;
    wr(PIN_IRQ_MASK_ADDR, 8'h40);
    wr(CORE_CONTROL_ADDR, 8'h00);
    cyc(3);
    `CHK(irq_req, 1'b1);
    `CHK(irq_vector, VEC_EXT_IRQ0);
    rd(PIN_IRQ_FLAGS_ADDR, 8'h00);
    cyc(8);
    `CHK(irq_req, 1'b1);
    status_word_ie <= 1'b0;
    cyc(3);
    `CHK(irq_req, 1'b0);
    status_word_ie <= 1'b1;
    ext_irq0_pin <= 1'b1;
    cyc(3);
    `CHK(irq_req, 1'b0);
    `CHK(32'(rd_q.size() + vec_q.size()), 32'h0);
    final_report();
  end
endmodule : test_pin_timer_irq_sleep_control
`default_nettype wire
